// ### engine_power_on_sequencer_test.sv
// Self-checking bench for the engine power-on sequencer
`timescale 1ns/1ps
module engine_power_on_sequencer_test;
   import epos_pkg::*;
   logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_toner_low = 1'b0, i_top_done = 1'b0;
   logic i_motor_stopped = 1'b0, i_job_end = 1'b0, go = 1'b0, i_print_request_n;
   logic [7:0] i_fix_temp = 8'h00;
   logic [3:0] i_keys = 4'h0;
   logic o_heater_on, o_fix_standby, o_main_motor, o_toner_low, o_toner_valid, o_service_mode;
   epos_state_t o_state;
   int err_total = 0, compares = 0, cyc = 0, k;
   // Rows: temperature, cycles after release, expected state
   logic [7:0] row_t [7] = '{8'h8B, 8'h8C, 8'h95, 8'h95, 8'h96, 8'h96, 8'h90};
   int row_c [7] = '{150, 60, 112, 140, 115, 90, 150};
   logic [7:0] row_s [7] = '{8'h00, 8'h01, 8'h01, 8'h02, 8'h02, 8'h01, 8'h01};
   // Timers shortened so the early exits fit a short run
   epos_sequencer #(.P_EXIT_A_CYC(100), .P_EXIT_B_CYC(120), .P_KEY_HOLD_CYC(10)) i_epos_sequencer (
      .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_fix_temp(i_fix_temp), .i_toner_low(i_toner_low),
      .i_top_done(i_top_done), .i_motor_stopped(i_motor_stopped), .i_print_request_n(i_print_request_n),
      .i_job_end(i_job_end), .i_keys(i_keys), .o_heater_on(o_heater_on), .o_fix_standby(o_fix_standby),
      .o_main_motor(o_main_motor), .o_toner_low(o_toner_low), .o_toner_valid(o_toner_valid),
      .o_service_mode(o_service_mode), .o_state(o_state));
   epos_video_model i_epos_video_model (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_go(go),
      .i_state(o_state), .o_print_request_n(i_print_request_n));
   // 50 ns period
   initial begin
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   // Hang guard well above the longest sequence
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total = err_total + 1;
         conclude();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   // Reset 12 cycles, then release with given temperature and keys
   task automatic restart(input logic [7:0] t, input logic [3:0] kk);
      @(posedge i_clk_sys);
      i_nrst <= 1'b0;
      i_fix_temp <= t;
      i_keys <= kk;
      i_motor_stopped <= 1'b0;
      ticks(12);
      i_nrst <= 1'b1;
   endtask
   task automatic wait_state(input logic [7:0] s);
      int n;
      n = 0;
      // Look 1 ns after each edge so the state has settled
      #1;
      while (o_state !== epos_state_t'(s) && n < 300) begin
         @(posedge i_clk_sys);
         #1;
         n = n + 1;
      end
   endtask
   task automatic conclude();
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      // Heat-up threshold and both early exits by table
      for (k = 0; k < 7; k++) begin
         restart(row_t[k], 4'h0);
         ticks(row_c[k]);
         #1;
         chk(8'(o_state), row_s[k]);
      end
      // Both exits straight from heat-up when the roller jumps late past 150 degrees
      restart(8'h80, 4'h0);
      ticks(125);
      i_fix_temp <= 8'h96;
      ticks(5);
      #1;
      chk(8'(o_state), 8'h02);
      // During reset all outputs except o_toner_low checked low
      @(posedge i_clk_sys);
      i_nrst <= 1'b0;
      ticks(4);
      #1;
      chk({o_heater_on, o_main_motor, o_fix_standby, o_toner_valid, o_service_mode, o_state}, 8'h00);
      // Normal power-on: spin with toner sample, then idle-ready
      restart(8'h8C, 4'h0);
      i_toner_low <= 1'b1;
      wait_state(8'h01);
      chk(8'({o_main_motor, o_heater_on}), 8'h03);
      ticks(8);
      i_motor_stopped <= 1'b1;
      wait_state(8'h02);
      chk(8'({o_main_motor, o_fix_standby, o_heater_on, o_toner_valid, o_toner_low}), 8'h0B);
      // Toner-low detector clears only after the spin, so it must not be taken
      ticks(1);
      i_toner_low <= 1'b0;
      ticks(39);
      #1;
      chk({o_toner_low, 4'h0, o_state}, 8'h82);
      // Print job through every interval
      ticks(1);
      go <= 1'b1;
      ticks(1);
      go <= 1'b0;
      wait_state(8'h03);
      chk(8'(o_state), 8'h03);
      ticks(1);
      i_motor_stopped <= 1'b0;
      i_top_done <= 1'b1;
      wait_state(8'h04);
      chk(8'(o_state), 8'h04);
      ticks(1);
      i_top_done <= 1'b0;
      i_job_end <= 1'b1;
      wait_state(8'h05);
      chk(8'(o_state), 8'h05);
      ticks(1);
      i_job_end <= 1'b0;
      i_motor_stopped <= 1'b1;
      wait_state(8'h02);
      ticks(30);
      #1;
      chk({o_fix_standby, 4'h0, o_state}, 8'h82);
      // Service entry with and without the first key pair
      restart(8'h8C, 4'h3);
      wait_state(8'h01);
      ticks(1);
      i_keys <= 4'hE;
      ticks(30);
      #1;
      chk(8'(o_service_mode), 8'h01);
      restart(8'h8C, 4'h0);
      wait_state(8'h01);
      ticks(1);
      i_keys <= 4'hE;
      ticks(30);
      #1;
      chk(8'(o_service_mode), 8'h00);
      conclude();
   end
endmodule

// ### epos_pkg.sv
// Package for the engine power-on sequencer: states, thresholds and timing constants
package epos_pkg;

   // Clock rate in Hz
   localparam longint CLK_HZ = 20000000;

   // Temperature thresholds in degrees C, unsigned 8-bit sensor reading
   localparam logic [7:0] TEMP_WARM_C = 8'h8C;   // 140
   localparam logic [7:0] TEMP_HOT_C = 8'h96;    // 150
   localparam logic [7:0] TEMP_WARMER_C = 8'h91; // 145

   // Early-exit times in seconds, and derived cycle counts (least times, so round up)
   localparam longint EXIT_A_SEC = 25;
   localparam longint EXIT_B_SEC = 27;
   localparam longint EXIT_A_CYC = EXIT_A_SEC * CLK_HZ;
   localparam longint EXIT_B_CYC = EXIT_B_SEC * CLK_HZ;

   // Service key hold time in milliseconds and cycles
   localparam longint KEY_HOLD_MS = 1000;
   localparam longint KEY_HOLD_CYC = (KEY_HOLD_MS * CLK_HZ + 999) / 1000;

   // Width of the long elapsed-time counters
   localparam int TMR_W = 30;

   // Reset values
   localparam logic [TMR_W-1:0] TMR_RST = 30'h0;

   // Cycles after reset release before the synchronised pins carry real values
   localparam logic [TMR_W-1:0] SYNC_FILL = 30'h2;

   // Panel key bit positions
   localparam int KEY_GO = 0;
   localparam int KEY_MENU = 1;
   localparam int KEY_VALUE = 2;
   localparam int KEY_ENTER = 3;
   localparam int KEY_N = 4;

   // Engine intervals
   typedef enum logic [2:0] {
      EPOS_HEAT_UP,
      EPOS_HEAT_UP_SPIN,
      EPOS_IDLE_READY,
      EPOS_PRE_PRINT_SPIN,
      EPOS_PRINT,
      EPOS_FINAL_SPIN
   } epos_state_t;

   // Service entry steps
   typedef enum logic [1:0] {
      EPOS_SVC_FIRST,
      EPOS_SVC_SECOND,
      EPOS_SVC_ON,
      EPOS_SVC_OFF
   } epos_svc_t;

endpackage

// ### epos_sequencer.sv
// Engine power-on interval sequencer with service-menu key detection
`timescale 1ns/1ps
// What this block does
// RULE_01 - After power-on stay in heat-up, heater on, until the roller reaches 140 degrees.
// RULE_02 - After heat-up run the heat-up spin, turning the main motor on and then off before leaving.
// RULE_03 - Sample the toner-level detector only during the heat-up spin.
// RULE_04 - After the power-on waits hold idle-ready with the roller at standby until print request asserts.
// RULE_05 - After the final spin return to idle-ready and stay until a new print request; a request during the final spin jumps to the pre-print spin.
// RULE_06 - Leave the wait for idle-ready once 25 s of heater time and at least 150 degrees are reached.
// RULE_07 - Also leave the wait once 27 s of heater time and at least 145 degrees are reached.
// RULE_08 - Names ending in _n are active low, all others active high, on both sides. The reset i_nrst is active low as well.
// RULE_09 - Enter service mode only after go plus menu held to heat-up display, then menu value enter for 1 s.
// RULE_10 - A print request in idle-ready moves at once to the pre-print spin.
// RULE_11 - Expose the current interval as one encoded state that changes only on these conditions.
module epos_sequencer
   import epos_pkg::*;
#(
   parameter longint P_EXIT_A_CYC = epos_pkg::EXIT_A_CYC,
   parameter longint P_EXIT_B_CYC = epos_pkg::EXIT_B_CYC,
   parameter longint P_KEY_HOLD_CYC = epos_pkg::KEY_HOLD_CYC
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // Sensors, asynchronous
   input wire logic [7:0] i_fix_temp,
   input wire logic i_toner_low,
   input wire logic i_top_done,
   input wire logic i_motor_stopped,
   // Video controller
   input wire logic i_print_request_n,
   input wire logic i_job_end,
   // Operation panel keys, active high
   input wire logic [epos_pkg::KEY_N-1:0] i_keys,
   // Loads and status
   output logic o_heater_on,
   output logic o_fix_standby,
   output logic o_main_motor,
   output logic o_toner_low,
   output logic o_toner_valid,
   output logic o_service_mode,
   output epos_pkg::epos_state_t o_state
);
   import epos_pkg::*;

   localparam int SW = 8 + 5 + KEY_N;

   logic [SW-1:0] sync_w;
   logic [7:0] temp_s;
   logic toner_s, top_s, stop_s, prn_n_s, jend_s;
   logic [KEY_N-1:0] keys_s;
   epos_state_t state_r;
   epos_svc_t svc_r;
   logic [TMR_W-1:0] heat_tmr_r;
   logic [TMR_W-1:0] key_tmr_r;
   logic spin_on_r;
   logic exit_a, exit_b, combo1, combo2;

   // Every input pin except the reset crosses two flip-flops before use
   epos_sync #(.W(SW)) u_sync (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_async({i_fix_temp, i_toner_low, i_top_done, i_motor_stopped, i_print_request_n, i_job_end, i_keys}),
      .o_sync(sync_w)
   );
   assign {temp_s, toner_s, top_s, stop_s, prn_n_s, jend_s, keys_s} = sync_w;

   // Joint time and temperature exits from the wait
   assign exit_a = (heat_tmr_r >= TMR_W'(P_EXIT_A_CYC)) && (temp_s >= TEMP_HOT_C); // RULE_06
   assign exit_b = (heat_tmr_r >= TMR_W'(P_EXIT_B_CYC)) && (temp_s >= TEMP_WARMER_C); // RULE_07
   assign combo1 = keys_s[KEY_GO] && keys_s[KEY_MENU];
   assign combo2 = keys_s[KEY_MENU] && keys_s[KEY_VALUE] && keys_s[KEY_ENTER];

   // Heater elapsed time since power-on; saturates so the exits stay true
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         heat_tmr_r <= TMR_RST;
      end else if (heat_tmr_r != {TMR_W{1'b1}}) begin
         heat_tmr_r <= heat_tmr_r + 1'b1;
      end
   end

   // Interval state machine
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         state_r <= EPOS_HEAT_UP;
         spin_on_r <= 1'b0;
      end else begin
         case (state_r)
            EPOS_HEAT_UP: begin
               if (exit_a || exit_b) begin
                  state_r <= EPOS_IDLE_READY; // RULE_06 RULE_07
               end else if (temp_s >= TEMP_WARM_C) begin
                  state_r <= EPOS_HEAT_UP_SPIN; // RULE_01
                  spin_on_r <= 1'b0;
               end
            end
            EPOS_HEAT_UP_SPIN: begin
               // Motor first runs, then must be seen stopped before leaving, unless exit_a or exit_b fires first
               if (exit_a || exit_b) begin
                  state_r <= EPOS_IDLE_READY; // RULE_06 RULE_07
               end else if (!spin_on_r) begin
                  spin_on_r <= 1'b1; // RULE_02
               end else if (!stop_s) begin
                  spin_on_r <= 1'b1;
               end else begin
                  state_r <= EPOS_IDLE_READY; // RULE_02
               end
            end
            EPOS_IDLE_READY: begin
               if (!prn_n_s) begin
                  state_r <= EPOS_PRE_PRINT_SPIN; // RULE_04 RULE_10 RULE_08
               end
            end
            EPOS_PRE_PRINT_SPIN: begin
               if (top_s) begin
                  state_r <= EPOS_PRINT;
               end
            end
            EPOS_PRINT: begin
               if (jend_s) begin
                  state_r <= EPOS_FINAL_SPIN;
               end
            end
            EPOS_FINAL_SPIN: begin
               // New request jumps straight to the pre-print spin
               if (!prn_n_s) begin
                  state_r <= EPOS_PRE_PRINT_SPIN;
               end else if (stop_s) begin
                  state_r <= EPOS_IDLE_READY; // RULE_05
               end
            end
            default: state_r <= EPOS_HEAT_UP;
         endcase
      end
   end

   // Load outputs, all registered
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         o_heater_on <= 1'b0;
         o_fix_standby <= 1'b0;
         o_main_motor <= 1'b0;
         o_state <= EPOS_HEAT_UP;
      end else begin
         o_heater_on <= (state_r == EPOS_HEAT_UP) || (state_r == EPOS_HEAT_UP_SPIN); // RULE_01
         o_fix_standby <= (state_r == EPOS_IDLE_READY); // RULE_04
         // In the heat-up spin the motor is commanded on only in the first cycle, then off so it can be seen stopped
         o_main_motor <= ((state_r == EPOS_HEAT_UP_SPIN) && !spin_on_r)
            || (state_r == EPOS_PRE_PRINT_SPIN) || (state_r == EPOS_PRINT); // RULE_02
         o_state <= state_r; // RULE_11
      end
   end

   // Toner level is only trusted when taken during the heat-up spin
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         o_toner_low <= 1'b0;
         o_toner_valid <= 1'b0;
      end else if (state_r == EPOS_HEAT_UP_SPIN) begin
         o_toner_low <= toner_s; // RULE_03
         o_toner_valid <= 1'b1;
      end
   end

   // Service entry: first combination held until heat-up ends, then second held 1 s
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         svc_r <= EPOS_SVC_FIRST;
         key_tmr_r <= TMR_RST;
         o_service_mode <= 1'b0;
      end else begin
         case (svc_r)
            EPOS_SVC_FIRST: begin
               // Keys read zero until the sync chain has refilled after reset
               if (heat_tmr_r < SYNC_FILL) begin
                  svc_r <= EPOS_SVC_FIRST;
               end else if (!combo1) begin
                  svc_r <= EPOS_SVC_OFF; // RULE_09
               end else if (state_r != EPOS_HEAT_UP) begin
                  svc_r <= EPOS_SVC_SECOND;
                  key_tmr_r <= TMR_RST;
               end
            end
            EPOS_SVC_SECOND: begin
               if (!combo2) begin
                  key_tmr_r <= TMR_RST;
               end else if (key_tmr_r >= TMR_W'(P_KEY_HOLD_CYC - 1)) begin
                  svc_r <= EPOS_SVC_ON; // RULE_09
                  o_service_mode <= 1'b1;
               end else begin
                  key_tmr_r <= key_tmr_r + 1'b1;
               end
            end
            default: svc_r <= svc_r;
         endcase
      end
   end

   // Checks
   a_heat_exit: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_01
      (state_r == EPOS_HEAT_UP) && (temp_s < TEMP_WARM_C) && !exit_a && !exit_b |=> state_r == EPOS_HEAT_UP)
      else $error("heat-up left too early");
   a_spin_motor: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_02
      $rose(state_r == EPOS_HEAT_UP_SPIN) && !exit_a && !exit_b |=> o_main_motor)
      else $error("motor not started in spin");
   a_toner_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_03
      state_r != EPOS_HEAT_UP_SPIN |=> $stable(o_toner_low))
      else $error("toner sampled outside spin");
   a_idle_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_04
      (state_r == EPOS_IDLE_READY) && prn_n_s |=> state_r == EPOS_IDLE_READY)
      else $error("idle left without request");
   a_final_back: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_05
      (state_r == EPOS_FINAL_SPIN) && prn_n_s && stop_s |=> state_r == EPOS_IDLE_READY)
      else $error("final spin did not return");
   a_exit_a: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_06
      (state_r == EPOS_HEAT_UP) && exit_a |=> state_r == EPOS_IDLE_READY)
      else $error("exit 25 s missed");
   a_exit_b: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_07
      (state_r == EPOS_HEAT_UP) && exit_b |=> state_r == EPOS_IDLE_READY)
      else $error("exit 27 s missed");
   a_svc_entry: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_09
      $rose(o_service_mode) |-> $past(combo2) && $past(svc_r) == EPOS_SVC_SECOND)
      else $error("service entered without keys");
   a_print_go: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_10
      (state_r == EPOS_IDLE_READY) && !prn_n_s |=> state_r == EPOS_PRE_PRINT_SPIN ##1 o_state == EPOS_PRE_PRINT_SPIN)
      else $error("request not taken");

   c_spin: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) $rose(state_r == EPOS_HEAT_UP_SPIN));
   c_idle: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) $rose(state_r == EPOS_IDLE_READY));
   c_final: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) $fell(state_r == EPOS_FINAL_SPIN));
   c_svc: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) $rose(o_service_mode));

endmodule

// ### epos_sync.sv
// Two-flip-flop synchroniser for a group of level inputs
`timescale 1ns/1ps
module epos_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // Data
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   logic [W-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         meta_r <= '0;
         o_sync <= '0;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end

endmodule

// ### epos_video_model.sv
// Video controller model that raises the active-low print request
`timescale 1ns/1ps
module epos_video_model
   import epos_pkg::*;
#(
   parameter int P_LAG = 3
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_nrst,
   // Job start from the bench, engine state seen back
   input wire logic i_go,
   input wire epos_pkg::epos_state_t i_state,
   // Request to the engine
   output logic o_print_request_n
);
   import epos_pkg::*;
   logic [7:0] lag_r;
   logic busy_r;
   // A slow host waits P_LAG cycles; released line idles high, inactive
   always_ff @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         busy_r <= 1'b0;
         lag_r <= 8'h00;
         o_print_request_n <= 1'b1;
      end else if (i_go && !busy_r) begin
         busy_r <= 1'b1;
         lag_r <= 8'h00;
      end else if (busy_r && o_print_request_n && lag_r < P_LAG) begin
         lag_r <= lag_r + 8'h01;
      end else if (busy_r && o_print_request_n) begin
         o_print_request_n <= 1'b0;
      end else if (i_state == EPOS_PRE_PRINT_SPIN) begin
         // Let go once the engine has taken the job
         o_print_request_n <= 1'b1;
         busy_r <= 1'b0;
      end
   end
endmodule
